/* File: rtl/scr_bank_if.sv */
// Purpose: Link between the selector top and one channel register bank
// Assumes: One instance per channel
// Notes:   Strobes are one-cycle pulses on core_clk
`timescale 1ns/1ps
interface scr_bank_if;
    import scr_pkg::*;
    logic      wr_p;
    logic      rd_p;
    scr_byte_t wdata;
    scr_idx_t  idx;
    scr_byte_t mode;
    scr_byte_t rxp;
    scr_byte_t misc;
    scr_byte_t txp;
    scr_byte_t mtrx;
    scr_byte_t extf;
    scr_byte_t prime;
    logic      crc_chk;
    logic      crc_gen;
    logic      eom_clr;
    modport bank (input wr_p, rd_p, wdata,
                  output idx, mode, rxp, misc, txp, mtrx, extf, prime, crc_chk, crc_gen, eom_clr);
    modport top  (output wr_p, rd_p, wdata,
                  input idx, mode, rxp, misc, txp, mtrx, extf, prime, crc_chk, crc_gen, eom_clr);
endinterface : scr_bank_if

/* File: rtl/scr_chan_bank.sv */
// Purpose: Pointer and write registers of one channel
// Assumes: wr_p and rd_p are single-cycle, never together
// Notes:   Pointer falls back to zero after each access to another register
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_chan_bank
    import scr_pkg::*;
(
    input wire logic  core_clk,
    input wire logic  rst_n,
    input wire logic  ce,
    scr_bank_if.bank  bus
);
    scr_ptr_state_t state_q;
    scr_ptr_state_t state_d;
    scr_idx_t       idx_q;
    scr_byte_t      regs_q [16];
    scr_byte_t      prime_q;
    logic           crc_chk_q;
    logic           crc_gen_q;
    logic           eom_clr_q;

    wire            ptr_wr   = bus.wr_p && (state_q == SCR_PTR_ZERO);
    wire            reg_wr   = bus.wr_p && (state_q == SCR_PTR_SET);
    wire [1:0]      rcmd     = bus.wdata[`SCR_RCMD_MSB:`SCR_RCMD_LSB];
    wire            high_sel = bus.wdata[`SCR_PCMD_MSB:`SCR_PCMD_LSB] == `SCR_PCMD_HIGH;
    wire scr_idx_t  idx_d    = {high_sel, bus.wdata[2:0]}; // R2 R8
    wire            prime_wr = reg_wr && (idx_q == `SCR_IDX_FCH)
                               && regs_q[`SCR_IDX_EXTF][`SCR_PRIME_EN_BIT];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SCR_PTR_ZERO: if (bus.wr_p) state_d = SCR_PTR_SET; // R1
            SCR_PTR_SET:  if (bus.wr_p || bus.rd_p) state_d = SCR_PTR_ZERO;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q   <= SCR_PTR_ZERO;
            idx_q     <= `SCR_IDX_PTR;
            crc_chk_q <= 1'b0;
            crc_gen_q <= 1'b0;
            eom_clr_q <= 1'b0;
            prime_q   <= `SCR_RST_BYTE;
            for (int i = 0; i < 16; i++) regs_q[i] <= `SCR_RST_BYTE;
        end else if (ce) begin
            state_q   <= state_d;
            crc_chk_q <= ptr_wr && (rcmd == `SCR_RCMD_CRC_CHK); // R6
            crc_gen_q <= ptr_wr && (rcmd == `SCR_RCMD_CRC_GEN); // R6
            eom_clr_q <= ptr_wr && (rcmd == `SCR_RCMD_EOM_CLR); // R7
            if (ptr_wr) idx_q <= idx_d; // R1
            if (prime_wr) prime_q <= bus.wdata;
            else if (reg_wr) regs_q[idx_q] <= bus.wdata;
        end
    end

    assign bus.idx     = (state_q == SCR_PTR_SET) ? idx_q : `SCR_IDX_PTR;
    assign bus.mode    = regs_q[`SCR_IDX_MODE];
    assign bus.rxp     = regs_q[`SCR_IDX_RXP];
    assign bus.misc    = regs_q[`SCR_IDX_MISC];
    assign bus.txp     = regs_q[`SCR_IDX_TXP];
    assign bus.mtrx    = regs_q[`SCR_IDX_MTRX];
    assign bus.extf    = regs_q[`SCR_IDX_EXTF];
    assign bus.prime   = prime_q;
    assign bus.crc_chk = crc_chk_q;
    assign bus.crc_gen = crc_gen_q;
    assign bus.eom_clr = eom_clr_q;
endmodule : scr_chan_bank

/* File: rtl/scr_defs.svh */
// Purpose: Constants of the serial controller register selection block
// Assumes: Included by bare name from both design modules
// Notes:   Definitions only
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
`define SCR_RST_BYTE      8'h00
`define SCR_RCMD_NULL     2'h0
`define SCR_RCMD_CRC_CHK  2'h1
`define SCR_RCMD_CRC_GEN  2'h2
`define SCR_RCMD_EOM_CLR  2'h3
`define SCR_PCMD_HIGH     3'h1
`define SCR_RCMD_MSB      7
`define SCR_RCMD_LSB      6
`define SCR_PCMD_MSB      5
`define SCR_PCMD_LSB      3
`define SCR_FIFO_EN_BIT   2
`define SCR_PRIME_EN_BIT  0
`define SCR_EXT_RD_BIT    6
`define SCR_IDX_PTR       4'h0
`define SCR_IDX_MODE      4'h1
`define SCR_IDX_VECTOR    4'h2
`define SCR_IDX_RXP       4'h3
`define SCR_IDX_MISC      4'h4
`define SCR_IDX_TXP       4'h5
`define SCR_IDX_FCL       4'h6
`define SCR_IDX_FCH       4'h7
`define SCR_IDX_MASTER    4'h9
`define SCR_IDX_B13       4'h9
`define SCR_IDX_MTRX      4'hA
`define SCR_IDX_B15       4'hB
`define SCR_IDX_PRIME_RD  4'hE
`define SCR_IDX_EXTF      4'hF
`endif

/* File: rtl/scr_pkg.sv */
// Purpose: Types of the serial controller register selection block
// Assumes: Constants live in scr_defs.svh
// Notes:   Types only
package scr_pkg;
    typedef logic [7:0] scr_byte_t;
    typedef logic [3:0] scr_idx_t;
    typedef enum logic {SCR_PTR_ZERO, SCR_PTR_SET} scr_ptr_state_t;
endpackage : scr_pkg

/* File: rtl/scr_reg_select.sv */
// Purpose: Indirect register selection of a two-channel serial controller
// Assumes: Host bus pins are asynchronous to core_clk; read images come from core logic
// Notes:   Strobes act on their rising edge after two-flop synchronisation
// Function
// R1: The low three pointer bits choose which of registers 0 to 7 the next access reaches.
// R2: Pointer command 001 moves that choice to registers 8 to 15.
// R3: Status FIFO enable returns frame count registers at 6 and 7, else images of 2 and 3.
// R4: Extended read returns write registers at indices 4, 5, 9, 11 and 14.
// R5: Without extended read, 4, 5, 9 and 11 return read images 0, 1, 13 and 15.
// R6: Reset codes 01 and 10 pulse checker and generator CRC resets; 00 does nothing.
// R7: Reset code 11 pulses the end-of-message latch clear of the selected channel.
// R8: In the high bank index 111 selects register 15 and 000 to 110 select 8 to 14.
// R9: Channel select high steers to channel A, low to B; vector and master are shared.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_reg_select
    import scr_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              host_wr_pin,
    input  wire logic              host_rd_pin,
    input  wire logic              host_chan_a_pin,
    input  wire logic [7:0]        host_data_in,
    output logic      [7:0]        host_data_out,
    output logic                   host_data_oe,
    input  wire logic [15:0][7:0]  rr_a,
    input  wire logic [15:0][7:0]  rr_b,
    output logic      [1:0]        crc_chk_rst,
    output logic      [1:0]        crc_gen_rst,
    output logic      [1:0]        eom_clr,
    output logic      [7:0]        vector_reg,
    output logic      [7:0]        master_int_ctrl,
    output logic      [7:0]        int_dma_mode_a,
    output logic      [7:0]        int_dma_mode_b
);
    logic [2:0] wr_s_q;
    logic [2:0] rd_s_q;
    logic [1:0] sel_s_q;
    scr_byte_t  data_s1_q;
    scr_byte_t  data_s2_q;
    scr_byte_t  rdata_q;
    logic       oe_q;
    scr_byte_t  vector_q;
    scr_byte_t  master_q;

    scr_bank_if ia ();
    scr_bank_if ib ();

    scr_chan_bank u_bank_a (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .bus(ia.bank));
    scr_chan_bank u_bank_b (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .bus(ib.bank));

    function automatic scr_byte_t read_pick(input scr_idx_t idx, input logic [15:0][7:0] rr,
                                            input scr_byte_t w3, input scr_byte_t w4,
                                            input scr_byte_t w5, input scr_byte_t w10,
                                            input scr_byte_t wp, input scr_byte_t w15);
        logic fifo;
        logic ext;
        scr_byte_t v;
        fifo = w15[`SCR_FIFO_EN_BIT];
        ext  = wp[`SCR_EXT_RD_BIT];
        v    = rr[idx];
        unique case (idx)
            `SCR_IDX_MISC:     v = ext ? w4  : rr[0];  // R4 R5
            `SCR_IDX_TXP:      v = ext ? w5  : rr[1];  // R4 R5
            `SCR_IDX_FCL:      v = fifo ? rr[6] : rr[2]; // R3
            `SCR_IDX_FCH:      v = fifo ? rr[7] : rr[3]; // R3
            `SCR_IDX_B13:      v = ext ? w3  : rr[13]; // R4 R5
            `SCR_IDX_B15:      v = ext ? w10 : rr[15]; // R4 R5
            `SCR_IDX_PRIME_RD: v = ext ? wp  : rr[14]; // R4
            default:           v = rr[idx];
        endcase
        return v;
    endfunction : read_pick

    wire        wr_p  = wr_s_q[1] && !wr_s_q[2];
    wire        rd_p  = rd_s_q[1] && !rd_s_q[2];
    wire        sel_a = sel_s_q[1];
    wire        wr_a  = wr_p && sel_a;  // R9
    wire        wr_b  = wr_p && !sel_a; // R9
    wire        rd_a  = rd_p && sel_a;
    wire        rd_b  = rd_p && !sel_a;
    wire scr_byte_t rd_mux_a = read_pick(ia.idx, rr_a, ia.rxp, ia.misc, ia.txp, ia.mtrx,
                                         ia.prime, ia.extf);
    wire scr_byte_t rd_mux_b = read_pick(ib.idx, rr_b, ib.rxp, ib.misc, ib.txp, ib.mtrx,
                                         ib.prime, ib.extf);
    wire scr_byte_t rd_vec   = sel_a ? rd_mux_a : rd_mux_b;
    wire        vec_wr = (wr_a && ia.idx == `SCR_IDX_VECTOR) || (wr_b && ib.idx == `SCR_IDX_VECTOR);
    wire        mst_wr = (wr_a && ia.idx == `SCR_IDX_MASTER) || (wr_b && ib.idx == `SCR_IDX_MASTER);

    assign ia.wr_p  = wr_a;
    assign ia.rd_p  = rd_a;
    assign ia.wdata = data_s2_q;
    assign ib.wr_p  = wr_b;
    assign ib.rd_p  = rd_b;
    assign ib.wdata = data_s2_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_s_q    <= 3'h0;
            rd_s_q    <= 3'h0;
            sel_s_q   <= 2'h0;
            data_s1_q <= `SCR_RST_BYTE;
            data_s2_q <= `SCR_RST_BYTE;
        end else if (ce) begin
            wr_s_q    <= {wr_s_q[1:0], host_wr_pin};
            rd_s_q    <= {rd_s_q[1:0], host_rd_pin};
            sel_s_q   <= {sel_s_q[0], host_chan_a_pin};
            data_s1_q <= host_data_in;
            data_s2_q <= data_s1_q;
        end
    end

    // Shared registers are written from whichever channel addresses them
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q  <= `SCR_RST_BYTE;
            oe_q     <= 1'b0;
            vector_q <= `SCR_RST_BYTE;
            master_q <= `SCR_RST_BYTE;
        end else if (ce) begin
            oe_q <= rd_s_q[1];
            if (rd_p) rdata_q <= rd_vec;
            if (vec_wr) vector_q <= data_s2_q; // R9
            if (mst_wr) master_q <= data_s2_q; // R9
        end
    end

    assign host_data_out   = rdata_q;
    assign host_data_oe    = oe_q;
    assign crc_chk_rst     = {ia.crc_chk, ib.crc_chk};
    assign crc_gen_rst     = {ia.crc_gen, ib.crc_gen};
    assign eom_clr         = {ia.eom_clr, ib.eom_clr};
    assign vector_reg      = vector_q;
    assign master_int_ctrl = master_q;
    assign int_dma_mode_a  = ia.mode;
    assign int_dma_mode_b  = ib.mode;

    a_low_bank_ptr: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R1
        wr_a && ia.idx == 4'h0 && data_s2_q[5:3] == 3'h0 |=> ia.idx == {1'b0, $past(data_s2_q[2:0])})
        else $error("low bank pointer not taken");
    a_high_bank_ptr: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R2
        wr_b && ib.idx == 4'h0 && data_s2_q[5:3] == 3'h1 |=> ib.idx == {1'b1, $past(data_s2_q[2:0])})
        else $error("high bank pointer not taken");
    a_high_fifteen: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R8
        wr_a && ia.idx == 4'h0 && data_s2_q[5:0] == 6'h0F |=> ia.idx == 4'hF)
        else $error("high bank 111 not register 15");
    a_fifo_count: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R3
        rd_a && ia.idx == 4'h6 && ia.extf[2] |=> host_data_out == $past(rr_a[6]))
        else $error("fifo read wrong at 6");
    a_nofifo_image: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R3
        rd_b && ib.idx == 4'h7 && !ib.extf[2] |=> host_data_out == $past(rr_b[3]))
        else $error("image read wrong at 7");
    a_ext_read: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R4
        rd_a && ia.idx == 4'h9 && ia.prime[6] |=> host_data_out == $past(ia.rxp))
        else $error("extended read wrong at 9");
    a_base_read: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R5
        rd_b && ib.idx == 4'hB && !ib.prime[6] |=> host_data_out == $past(rr_b[15]))
        else $error("base read wrong at 11");
    a_crc_reset_cmd: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R6
        wr_a && ia.idx == 4'h0 |=> crc_chk_rst[1] == ($past(data_s2_q[7:6]) == 2'h1)
                                   && crc_gen_rst[1] == ($past(data_s2_q[7:6]) == 2'h2))
        else $error("crc reset command mismatch");
    a_eom_clear: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R7
        wr_b && ib.idx == 4'h0 && data_s2_q[7:6] == 2'h3 |=> eom_clr == 2'h1)
        else $error("eom clear not on channel b");
    a_chan_steer: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        wr_p |-> (ia.wr_p == sel_s_q[1]) && (ib.wr_p == !sel_s_q[1]))
        else $error("channel steering wrong");

    c_high_write: cover property (@(posedge core_clk) wr_a && ia.idx[3] ##1 1'b1);
    c_ext_read:   cover property (@(posedge core_clk) rd_b && ib.prime[6] && ib.idx == 4'hE);
    c_eom_pulse:  cover property (@(posedge core_clk) eom_clr != 2'h0);
endmodule : scr_reg_select

/* File: tb/scr_host_model.sv */
// Purpose: Host processor on the parallel bus of the register selector
// Assumes: Pins change on falling core_clk edges only
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module scr_host_model (
    input  logic       core_clk,
    output logic       host_wr_pin,
    output logic       host_rd_pin,
    output logic       host_chan_a_pin,
    output logic [7:0] host_data_in,
    input  logic [7:0] host_data_out,
    input  logic       host_data_oe
);
    initial begin
        host_wr_pin     = 1'b0;
        host_rd_pin     = 1'b0;
        host_chan_a_pin = 1'b0;
        host_data_in    = 8'h00;
    end

    // Select and data settle 4 cycles before the strobe, strobe high 6, low 4
    task automatic access(input logic rd, input logic chan_a, input logic [7:0] wdat,
                          output logic [7:0] rdat, output logic oe);
        @(negedge core_clk);
        host_chan_a_pin = chan_a;
        host_data_in    = rd ? ~host_data_in : wdat;
        repeat (4) @(negedge core_clk);
        host_rd_pin = rd;
        host_wr_pin = ~rd;
        repeat (6) @(negedge core_clk);
        rdat        = host_data_out;
        oe          = host_data_oe;
        host_rd_pin = 1'b0;
        host_wr_pin = 1'b0;
        repeat (4) @(negedge core_clk);
        host_data_in = ~host_data_in;
    endtask : access
endmodule : scr_host_model

/* File: tb/tb_scr_reg_select.sv */
// Purpose: Self-checking bench of the register selector
// Assumes: Host model drives the pins; bench drives read images
// Notes:   Shadow copies of write registers give expected reads
`timescale 1ns/1ps
module tb_scr_reg_select;
    import scr_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic wr, rd, cha, oe;
    logic [7:0] din, dout, vec, mic, mda, mdb;
    logic [15:0][7:0] rr_a, rr_b;
    logic [1:0] chk_p, gen_p, eom_p;
    logic [5:0] seen = 6'h00;
    logic [7:0] wsh [2][16];
    logic [7:0] prime [2];
    int error_cnt = 0;
    int check_count = 0;

    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) seen <= seen | {chk_p, gen_p, eom_p};

    scr_host_model i_scr_host_model (.core_clk(core_clk), .host_wr_pin(wr), .host_rd_pin(rd),
        .host_chan_a_pin(cha), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe));
    scr_reg_select i_scr_reg_select (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .host_wr_pin(wr), .host_rd_pin(rd), .host_chan_a_pin(cha), .host_data_in(din),
        .host_data_out(dout), .host_data_oe(oe), .rr_a(rr_a), .rr_b(rr_b),
        .crc_chk_rst(chk_p), .crc_gen_rst(gen_p), .eom_clr(eom_p), .vector_reg(vec),
        .master_int_ctrl(mic), .int_dma_mode_a(mda), .int_dma_mode_b(mdb));

    task automatic test_done();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Pointer write first, then the access itself
    task automatic wreg(input logic c, input scr_idx_t i, input logic [7:0] v);
        logic [7:0] d;
        logic       o;
        i_scr_host_model.access(1'b0, c, {2'b00, 2'b00, i[3], i[2:0]}, d, o);
        i_scr_host_model.access(1'b0, c, v, d, o);
        if (i == 4'h7 && wsh[c][15][0])
            prime[c] = v;
        else
            wsh[c][i] = v;
    endtask : wreg

    function automatic logic [7:0] exp_rd(input logic c, input scr_idx_t i);
        logic [15:0][7:0] r;
        logic             f;
        logic             e;
        r = c ? rr_a : rr_b;
        f = wsh[c][15][2];
        e = prime[c][6];
        case (i)
            4'h4:    return e ? wsh[c][4] : r[0];
            4'h5:    return e ? wsh[c][5] : r[1];
            4'h6:    return f ? r[6] : r[2];
            4'h7:    return f ? r[7] : r[3];
            4'h9:    return e ? wsh[c][3] : r[13];
            4'hB:    return e ? wsh[c][10] : r[15];
            4'hE:    return e ? prime[c] : r[14];
            default: return r[i];
        endcase
    endfunction : exp_rd

    task automatic read_all(input logic c);
        logic [7:0] d;
        logic       o;
        for (int i = 0; i < 16; i++) begin
            i_scr_host_model.access(1'b0, c, {4'h0, 1'(i > 7), 3'(i)}, d, o);
            i_scr_host_model.access(1'b1, c, 8'h00, d, o);
            chk(d, exp_rd(c, 4'(i)));
            chk({7'h00, o}, 8'h01);
        end
    endtask : read_all

    initial begin
        logic [7:0] d;
        logic       o;
        logic [5:0] ex;
        for (int n = 0; n < 16; n++) begin
            rr_a[n]    = {4'hA, 4'(n)};
            rr_b[n]    = {4'h5, 4'(n)};
            wsh[0][n]  = 8'h00;
            wsh[1][n]  = 8'h00;
        end
        prime[0] = 8'h00;
        prime[1] = 8'h00;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        chk(vec, 8'h00);
        chk(mic, 8'h00);
        chk({mda[3:0], mdb[3:0]}, 8'h00);
        $display("test reset done");
        wreg(1'b1, 4'h1, 8'h5A);
        wreg(1'b0, 4'h1, 8'hC3);
        chk(mda, 8'h5A);
        chk(mdb, 8'hC3);
        wreg(1'b0, 4'h2, 8'h44);
        chk(vec, 8'h44);
        wreg(1'b1, 4'h9, 8'h77);
        chk(mic, 8'h77);
        $display("test write steering done");
        // Frozen clock enable must swallow a whole pointer and data write
        @(negedge core_clk);
        ce = 1'b0;
        i_scr_host_model.access(1'b0, 1'b1, 8'h01, d, o);
        i_scr_host_model.access(1'b0, 1'b1, 8'h99, d, o);
        ce = 1'b1;
        chk(mda, 8'h5A);
        $display("test clock enable done");
        read_all(1'b1);
        read_all(1'b0);
        wreg(1'b1, 4'hF, 8'h04);
        wreg(1'b0, 4'hF, 8'h04);
        read_all(1'b1);
        read_all(1'b0);
        $display("test read map done");
        wreg(1'b1, 4'h3, 8'h13);
        wreg(1'b1, 4'h4, 8'h24);
        wreg(1'b1, 4'h5, 8'h35);
        wreg(1'b1, 4'hA, 8'h4A);
        wreg(1'b1, 4'hF, 8'h05);
        wreg(1'b1, 4'h7, 8'h40);
        wreg(1'b1, 4'hF, 8'h04);
        read_all(1'b1);
        read_all(1'b0);
        $display("test extended read done");
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                seen = 6'h00;
                ex   = 6'h00;
                if (k != 0) ex[6 - 2 * k + c] = 1'b1;
                i_scr_host_model.access(1'b0, 1'(c), {2'(k), 6'h00}, d, o);
                chk({2'b00, seen}, {2'b00, ex});
                chk({7'h00, o}, 8'h00);
                i_scr_host_model.access(1'b1, 1'(c), 8'h00, d, o);
                chk(d, c ? rr_a[0] : rr_b[0]);
            end
        end
        $display("test reset commands done");
        test_done();
    end

    initial begin
        #100000;
        error_cnt++;
        test_done();
    end
endmodule : tb_scr_reg_select
